// *** design/carrier_sense_cca_lqi.sv ***
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module carrier_sense_cca_lqi
  import cs_cca_pkg::*;
#(
  parameter int NPINS = 3
)(
  // clock and reset
  input  wire  logic                     mclk,
  input  wire  logic                     sys_rst,
  // register port
  input  wire  cs_cca_pkg::reg_req_t     bus,
  output logic [7:0]                     rdata,
  // receive chain
  input  wire  cs_cca_pkg::rssi_sample_t rssi_in,
  input  wire  cs_cca_pkg::rx_events_t   rx_evt,
  input  wire  cs_cca_pkg::symbol_t      sym,
  // radio controller
  input  wire  logic                     transmit_strobe,
  input  wire  logic                     synth_on_tx_strobe,
  output logic                           tx_enter,
  output logic                           tx_refused,
  output logic                           sync_search_en,
  // status out
  output cs_cca_pkg::append_t            append_out,
  output logic [NPINS-1:0]               general_output_pin
);
  import cs_cca_pkg::*;

  if (NPINS < 1 || NPINS > 4)
  begin : g_bad_pins
    $error("NPINS must be 1 to 4");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]       agc_magnitude_target;
    logic [2:0]       amp_gain_limit;
    logic [1:0]       digital_gain_limit;
    logic [3:0]       cs_absolute_offset;
    logic [1:0]       cs_relative_step;
    logic [1:0]       channel_clear_mode;
    logic             append_rx_status;
    logic             cs_sync_qualify;
    logic [7:0]       pin_sel;
    logic [7:0]       rssi;
    logic             rssi_frozen;
    logic [7:0]       prev;
    logic             prev_ok;
    logic             cs_abs;
    logic             cs_rel;
    logic             rxing;
    logic             lqi_busy;
    logic [5:0]       lqi_cnt;
    logic [9:0]       lqi_sum;
    logic [6:0]       lqi;
    logic [7:0]       rdata;
    logic             tx_enter;
    logic             tx_refused;
    logic             sync_en;
    append_t          app;
    logic [NPINS-1:0] pins;
  } state_t;

  state_t q;
  state_t d;

  // relative step in half-dB units, zero when disabled
  function automatic int rel_half(input logic [1:0] code);
    case (code)
      2'h1:    rel_half = 2 * REL_STEP1_DB;
      2'h2:    rel_half = 2 * REL_STEP2_DB;
      2'h3:    rel_half = 2 * REL_STEP3_DB;
      default: rel_half = 0;
    endcase
  endfunction : rel_half

  // ----------------------------------------------------------------
  // derived conditions
  // ----------------------------------------------------------------
  logic cs_now;
  logic clear_now;
  int   thr_half;
  int   ofs_db;
  int   sample;
  int   delta;
  int   step;
  logic strobe;

  assign cs_now = q.cs_abs | q.cs_rel;
  assign strobe = transmit_strobe | synth_on_tx_strobe;
  assign sample = int'($signed(rssi_in.value));
  assign delta  = sample - int'($signed(q.prev));
  assign step   = rel_half(q.cs_relative_step);

  always_comb
  begin
    // the 4-bit code can hold -8, which is outside the offset range
    ofs_db = int'($signed(q.cs_absolute_offset));
    if (ofs_db < OFFSET_MIN_DB)
    begin
      ofs_db = OFFSET_MIN_DB;
    end
    thr_half = 2 * (TARGET_BASE_DB + int'(q.agc_magnitude_target) * TARGET_STEP_DB
               + ofs_db
               - (GAIN_TOP_DB - int'(q.amp_gain_limit) * AMP_STEP_DB
                  - int'(q.digital_gain_limit) * DIGITAL_STEP_DB));
  end

  always_comb
  begin
    case (clear_mode_t'(q.channel_clear_mode))
      CCA_ALWAYS:   clear_now = 1'b1;
      CCA_RSSI_LOW: clear_now = !cs_now;
      CCA_NOT_RX:   clear_now = !q.rxing;
      default:      clear_now = !cs_now && !q.rxing;
    endcase
  end

  // ----------------------------------------------------------------
  // output pin selection
  // ----------------------------------------------------------------
  logic [NPINS-1:0] pin_d;

  // one decoder per pin, so each pin bit has a single driver
  function automatic logic pin_value(input logic [1:0] sel, input logic cs,
                                     input logic clr, input logic rx);
    case (pin_sel_t'(sel))
      PIN_CS:    pin_value = cs;
      PIN_CLEAR: pin_value = clr;
      PIN_RXING: pin_value = rx;
      default:   pin_value = 1'b0;
    endcase
  endfunction : pin_value

  for (genvar i = 0; i < NPINS; i++)
  begin : g_pin
    assign pin_d[i] = pin_value(q.pin_sel[2*i +: 2], cs_now, clear_now, q.rxing);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.pins = pin_d;
    d.tx_enter = 1'b0;
    d.tx_refused = 1'b0;
    d.app.valid = 1'b0;
    d.rdata = 8'h00;

    // register writes
    if (bus.wr)
    begin
      if (bus.addr == GAIN_CONTROL_REG_TWO_OFS)
      begin
        d.agc_magnitude_target = bus.wdata[TARGET_LSB +: 3];
        d.amp_gain_limit       = bus.wdata[AMP_LSB +: 3];
        d.digital_gain_limit   = bus.wdata[DIGITAL_LSB +: 2];
      end
      else if (bus.addr == GAIN_CONTROL_REG_ONE_OFS)
      begin
        d.cs_absolute_offset = bus.wdata[OFFSET_LSB +: 4];
        d.cs_relative_step   = bus.wdata[REL_LSB +: 2];
      end
      else if (bus.addr == RADIO_FSM_CONFIG_ONE_OFS)
      begin
        d.channel_clear_mode = bus.wdata[CLEAR_MODE_LSB +: 2];
      end
      else if (bus.addr == PACKET_CONTROL_ONE_OFS)
      begin
        d.append_rx_status = bus.wdata[APPEND_BIT];
        d.cs_sync_qualify  = bus.wdata[CS_SYNC_BIT];
      end
      else if (bus.addr == PIN_SELECT_OFS)
      begin
        d.pin_sel = bus.wdata;
      end
    end

    // register reads, data valid in the next cycle only
    if (bus.rd)
    begin
      if (bus.addr == GAIN_CONTROL_REG_TWO_OFS)
      begin
        d.rdata = {q.digital_gain_limit, q.amp_gain_limit, q.agc_magnitude_target};
      end
      else if (bus.addr == GAIN_CONTROL_REG_ONE_OFS)
      begin
        d.rdata = {2'h0, q.cs_relative_step, q.cs_absolute_offset};
      end
      else if (bus.addr == RADIO_FSM_CONFIG_ONE_OFS)
      begin
        d.rdata = {6'h00, q.channel_clear_mode};
      end
      else if (bus.addr == PACKET_CONTROL_ONE_OFS)
      begin
        d.rdata = {6'h00, q.cs_sync_qualify, q.append_rx_status};
      end
      else if (bus.addr == PIN_SELECT_OFS)
      begin
        d.rdata = q.pin_sel;
      end
      else if (bus.addr == PACKET_STATUS_REG_OFS)
      begin
        d.rdata[ST_CS]       = cs_now;
        d.rdata[ST_CLEAR]    = clear_now;
        d.rdata[ST_RXING]    = q.rxing;
        d.rdata[ST_CS_ABS]   = q.cs_abs;
        d.rdata[ST_CS_REL]   = q.cs_rel;
        d.rdata[ST_LQI_BUSY] = q.lqi_busy;
      end
      else if (bus.addr == RSSI_READOUT_OFS)
      begin
        d.rdata = q.rssi;
      end
      else if (bus.addr == LINK_QUALITY_OFS)
      begin
        d.rdata = {1'b0, q.lqi};
      end
    end

    // rssi samples and carrier sense
    if (rssi_in.valid)
    begin
      if (!q.rssi_frozen)
      begin
        d.rssi = rssi_in.value;
      end
      if (sample > thr_half)
      begin
        d.cs_abs = 1'b1;
      end
      else if (sample < thr_half - HYST_HALF_DB)
      begin
        d.cs_abs = 1'b0;
      end
      if (q.prev_ok && step != 0 && delta >= step)
      begin
        d.cs_rel = 1'b1;
      end
      else if (q.prev_ok && step != 0 && delta <= -step)
      begin
        d.cs_rel = 1'b0;
      end
      d.prev = rssi_in.value;
      d.prev_ok = 1'b1;
    end
    if (q.cs_relative_step == 2'h0)
    begin
      d.cs_rel = 1'b0;
    end

    // the freeze is released on entry so the first sample is taken
    if (rx_evt.rx_enter)
    begin
      d.rssi_frozen = 1'b0;
      d.prev_ok = 1'b0;
    end
    else if (rx_evt.sync_det)
    begin
      d.rssi_frozen = 1'b1;
    end

    // packet in progress; a new sync wins over a same-cycle end
    if (rx_evt.pkt_end || rx_evt.rx_abort)
    begin
      d.rxing = 1'b0;
    end
    if (rx_evt.sync_det)
    begin
      d.rxing = 1'b1;
    end

    // link quality over the symbols after sync
    if (rx_evt.sync_det)
    begin
      d.lqi_busy = 1'b1;
      d.lqi_cnt = 6'h00;
      d.lqi_sum = 10'h000;
    end
    else if (q.lqi_busy && sym.valid)
    begin
      d.lqi_sum = q.lqi_sum + {6'h00, sym.err};
      d.lqi_cnt = q.lqi_cnt + 6'h01;
      if (int'(q.lqi_cnt) == LQI_SYMBOLS - 1)
      begin
        d.lqi_busy = 1'b0;
        d.lqi = d.lqi_sum[9:3];
      end
    end

    // status bytes after the packet
    if (rx_evt.pkt_end && q.rxing && q.append_rx_status)
    begin
      d.app.valid = 1'b1;
      d.app.rssi_byte = q.rssi;
      d.app.quality_byte = {rx_evt.crc_ok, q.lqi};
    end

    // transmit only if clear while receiving
    if (strobe)
    begin
      if (!rx_evt.rx_active || clear_now)
      begin
        d.tx_enter = 1'b1;
      end
      else
      begin
        d.tx_refused = 1'b1;
      end
    end

    d.sync_en = rx_evt.rx_active && (!q.cs_sync_qualify || cs_now);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.agc_magnitude_target <= TARGET_RST;
      q.amp_gain_limit <= AMP_RST;
      q.digital_gain_limit <= DIGITAL_RST;
      q.cs_absolute_offset <= OFFSET_RST;
      q.cs_relative_step <= REL_RST;
      q.channel_clear_mode <= CLEAR_MODE_RST;
      q.pin_sel <= PIN_SEL_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata              = q.rdata;
  assign tx_enter           = q.tx_enter;
  assign tx_refused         = q.tx_refused;
  assign sync_search_en     = q.sync_en;
  assign append_out         = q.app;
  assign general_output_pin = q.pins;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_sync;
    rx_evt.sync_det && !rx_evt.rx_enter;
  endsequence

  sequence s_hold_rssi;
    $stable(q.rssi) [*2];
  endsequence

  a_rssi_hold: assert property (s_sync ##1 !rx_evt.rx_enter |=> s_hold_rssi or rx_evt.rx_enter)
    else $error("rssi readout changed while frozen");
  a_abs_raise: assert property (rssi_in.valid && sample > thr_half |=> q.cs_abs)
    else $error("absolute sense not raised");
  a_abs_drop: assert property (rssi_in.valid && sample < thr_half - HYST_HALF_DB |=> !q.cs_abs)
    else $error("absolute sense not dropped");
  a_rel_rise: assert property (rssi_in.valid && q.prev_ok && step != 0 && delta >= step
                               |=> q.cs_rel)
    else $error("relative sense not raised");
  a_rel_off: assert property (q.cs_relative_step == 2'h0 |=> !q.cs_rel)
    else $error("relative sense active while disabled");
  a_tx_block: assert property (strobe && rx_evt.rx_active && !clear_now
                               |=> !tx_enter && tx_refused)
    else $error("transmit entered with busy channel");
  a_tx_grant: assert property (strobe && clear_now |=> tx_enter && !tx_refused)
    else $error("transmit refused with clear channel");
  a_sync_gate: assert property (q.cs_sync_qualify && !cs_now |=> !sync_search_en)
    else $error("sync search without carrier sense");
  a_lqi_start: assert property (s_sync |=> q.lqi_busy && q.lqi_cnt == 6'h00 && q.rxing)
    else $error("link quality window not started");
  a_append_out: assert property (rx_evt.pkt_end && q.rxing && q.append_rx_status
                                 |=> append_out.valid ##1 !append_out.valid)
    else $error("status bytes not appended");

endmodule : carrier_sense_cca_lqi

`default_nettype wire

// *** design/cs_cca_pkg.sv ***
package cs_cca_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] GAIN_CONTROL_REG_TWO_OFS = 4'h0;
  localparam logic [3:0] GAIN_CONTROL_REG_ONE_OFS = 4'h1;
  localparam logic [3:0] RADIO_FSM_CONFIG_ONE_OFS = 4'h2;
  localparam logic [3:0] PACKET_CONTROL_ONE_OFS   = 4'h3;
  localparam logic [3:0] PIN_SELECT_OFS           = 4'h4;
  localparam logic [3:0] PACKET_STATUS_REG_OFS    = 4'h5;
  localparam logic [3:0] RSSI_READOUT_OFS         = 4'h6;
  localparam logic [3:0] LINK_QUALITY_OFS         = 4'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TARGET_LSB   = 0;
  localparam int AMP_LSB      = 3;
  localparam int DIGITAL_LSB  = 6;
  localparam int OFFSET_LSB   = 0;
  localparam int REL_LSB      = 4;
  localparam int CLEAR_MODE_LSB = 0;
  localparam int APPEND_BIT   = 0;
  localparam int CS_SYNC_BIT  = 1;
  localparam int ST_CS        = 0;
  localparam int ST_CLEAR     = 1;
  localparam int ST_RXING     = 2;
  localparam int ST_CS_ABS    = 3;
  localparam int ST_CS_REL    = 4;
  localparam int ST_LQI_BUSY  = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] TARGET_RST   = 3'h3;
  localparam logic [2:0] AMP_RST      = 3'h0;
  localparam logic [1:0] DIGITAL_RST  = 2'h0;
  localparam logic [3:0] OFFSET_RST   = 4'h0;
  localparam logic [1:0] REL_RST      = 2'h0;
  localparam logic [1:0] CLEAR_MODE_RST = 2'h3;
  localparam logic [7:0] PIN_SEL_RST  = 8'h00;

  // ----------------------------------------------------------------
  // gain and threshold arithmetic in dB, hysteresis in half dB, quality window in symbols
  // ----------------------------------------------------------------
  localparam int TARGET_BASE_DB = 24;
  localparam int TARGET_STEP_DB = 3;
  localparam int GAIN_TOP_DB    = 60;
  localparam int AMP_STEP_DB    = 3;
  localparam int DIGITAL_STEP_DB = 6;
  localparam int OFFSET_MIN_DB  = -7;
  localparam int HYST_HALF_DB   = 2;
  localparam int REL_STEP1_DB   = 6;
  localparam int REL_STEP2_DB   = 10;
  localparam int REL_STEP3_DB   = 14;
  localparam int LQI_SYMBOLS    = 64;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CCA_ALWAYS, CCA_RSSI_LOW, CCA_NOT_RX, CCA_BOTH} clear_mode_t;
  typedef enum logic [1:0] {PIN_CS, PIN_CLEAR, PIN_RXING, PIN_LOW} pin_sel_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } rssi_sample_t;

  typedef struct packed {
    logic rx_active;
    logic rx_enter;
    logic sync_det;
    logic pkt_end;
    logic rx_abort;
    logic crc_ok;
  } rx_events_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] err;
  } symbol_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rssi_byte;
    logic [7:0] quality_byte;
  } append_t;

endpackage : cs_cca_pkg

// *** verification/rx_chain_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// receive chain and packet engine stand-in
// ----------------------------------------------------------------
module rx_chain_model (
  // clock
  input  wire logic                    mclk,
  // towards the block
  output var  cs_cca_pkg::rssi_sample_t rssi_in,
  output var  cs_cca_pkg::rx_events_t   rx_evt,
  output var  cs_cca_pkg::symbol_t      sym
);
  import cs_cca_pkg::*;

  initial
  begin
    rssi_in = '0;
    rx_evt  = '0;
    sym     = '0;
  end

  // stale values are inverted so nothing relies on a held sample
  task automatic sample(input logic [7:0] v);
    @(posedge mclk);
    rssi_in <= '{valid: 1'b1, value: v};
    @(posedge mclk);
    rssi_in <= '{valid: 1'b0, value: ~v};
  endtask : sample

  // one-cycle event pulse, mask in rx_events_t bit order
  task automatic evt(input logic [5:0] m);
    @(posedge mclk);
    rx_evt <= rx_evt | m;
    @(posedge mclk);
    rx_evt <= rx_evt & ~m;
  endtask : evt

  task automatic level(input logic act, input logic crc);
    @(posedge mclk);
    rx_evt.rx_active <= act;
    rx_evt.crc_ok    <= crc;
  endtask : level

  // back-to-back symbols, error metric counts up from start
  task automatic symbols(input int n, input int start);
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      sym <= '{valid: 1'b1, err: 4'(start + i)};
    end
    @(posedge mclk);
    sym <= '{valid: 1'b0, err: ~sym.err};
  endtask : symbols
endmodule : rx_chain_model

`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import cs_cca_pkg::*;

  localparam int NPINS = 3;

  logic         mclk;
  logic         sys_rst;
  reg_req_t     bus;
  logic [7:0]   rdata;
  rssi_sample_t rssi_in;
  rx_events_t   rx_evt;
  symbol_t      sym;
  logic         transmit_strobe;
  logic         synth_on_tx_strobe;
  logic         tx_enter;
  logic         tx_refused;
  logic         sync_search_en;
  append_t      append_out;
  logic [NPINS-1:0] general_output_pin;
  int           n_errors = 0;
  int           checked  = 0;
  int           cases [4][3] = '{'{7, 0, -8}, '{7, 3, -7}, '{7, 3, 7}, '{2, 1, 3}};
  int           steps [3] = '{REL_STEP1_DB, REL_STEP2_DB, REL_STEP3_DB};
  logic [7:0]   t;
  int           s;

  carrier_sense_cca_lqi #(.NPINS(NPINS)) uut (
    .mclk               (mclk),
    .sys_rst            (sys_rst),
    .bus                (bus),
    .rdata              (rdata),
    .rssi_in            (rssi_in),
    .rx_evt             (rx_evt),
    .sym                (sym),
    .transmit_strobe    (transmit_strobe),
    .synth_on_tx_strobe (synth_on_tx_strobe),
    .tx_enter           (tx_enter),
    .tx_refused         (tx_refused),
    .sync_search_en     (sync_search_en),
    .append_out         (append_out),
    .general_output_pin (general_output_pin)
  );

  rx_chain_model far (
    .mclk    (mclk),
    .rssi_in (rssi_in),
    .rx_evt  (rx_evt),
    .sym     (sym)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // access and compare helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    check($sformatf("reg%0h", a), rdata, exp);
  endtask : rc

  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  function automatic logic [7:0] thr(int tgt, int amp, int dig, int ofs);
    int o;
    o = (ofs < OFFSET_MIN_DB) ? OFFSET_MIN_DB : ofs;
    return 8'(2 * (TARGET_BASE_DB + TARGET_STEP_DB * tgt + o
                   - (GAIN_TOP_DB - AMP_STEP_DB * amp - DIGITAL_STEP_DB * dig)));
  endfunction : thr

  task automatic strobe(input logic which, input logic clr);
    @(posedge mclk);
    if (which)
      synth_on_tx_strobe <= 1'b1;
    else
      transmit_strobe <= 1'b1;
    @(posedge mclk);
    transmit_strobe    <= 1'b0;
    synth_on_tx_strobe <= 1'b0;
    #1;
    check("tx_enter", 8'(tx_enter), 8'(clr));
    check("tx_refused", 8'(tx_refused), 8'(!clr));
  endtask : strobe

  task automatic cca(input int m, input logic cs, input logic rcv);
    logic clr;
    clr = (m == 0) || (m == 1 && !cs) || (m == 2 && !rcv) || (m == 3 && !cs && !rcv);
    wr(4'h2, 8'(m));
    settle();
    check("pins", 8'(general_output_pin), {5'h00, rcv, clr, cs});
    strobe(m[0], clr);
  endtask : cca

  // ----------------------------------------------------------------
  // watchdog, far above the few hundred cycles the tests need
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst            = 1'b1;
    bus                = '0;
    transmit_strobe    = 1'b0;
    synth_on_tx_strobe = 1'b0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rc(4'h0, 8'h03);
    rc(4'h1, 8'h00);
    rc(4'h2, 8'h03);
    rc(4'h3, 8'h00);
    rc(4'h4, 8'h00);
    rc(4'h5, 8'h02);
    rc(4'h7, 8'h00);
    rc(4'hF, 8'h00);
    wr(4'h5, 8'hFF);
    rc(4'h5, 8'h02);
    wr(4'h4, 8'h24);
    settle();
    check("pins", 8'(general_output_pin), 8'h02);
    // absolute sense at reset gains, threshold is negative
    t = thr(3, 0, 0, 0);
    far.sample(t);
    rc(4'h5, 8'h02);
    far.sample(t + 8'h01);
    settle();
    check("pins", 8'(general_output_pin), 8'h01);
    rc(4'h5, 8'h09);
    far.sample(t - 8'h02);
    rc(4'h5, 8'h09);
    far.sample(t - 8'h03);
    rc(4'h5, 8'h02);
    // amplifier limit is raised before the digital one
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h0, {2'(cases[i][1]), 3'(cases[i][0]), 3'h3});
      wr(4'h1, {4'h0, 4'(cases[i][2])});
      t = thr(3, cases[i][0], cases[i][1], cases[i][2]);
      far.sample(t);
      rc(4'h5, 8'h02);
      far.sample(t + 8'h01);
      rc(4'h5, 8'h09);
      far.sample(8'h80);
      rc(4'h5, 8'h02);
    end
    // relative sense, absolute threshold left high
    for (int k = 1; k < 4; k++)
    begin
      s = 2 * steps[k - 1];
      wr(4'h1, {2'b00, 2'(k), 4'h7});
      far.evt(6'h10);
      far.sample(8'(-100));
      far.sample(8'(-100 + s - 1));
      rc(4'h5, 8'h02);
      far.sample(8'(-100 + 2 * s - 1));
      rc(4'h5, 8'h11);
      far.sample(8'(-100 + s));
      rc(4'h5, 8'h11);
      far.sample(8'(-100));
      rc(4'h5, 8'h02);
    end
    // sync qualifier and channel assessment
    wr(4'h1, 8'h07);
    far.level(1'b1, 1'b1);
    wr(4'h3, 8'h02);
    far.sample(8'h80);
    settle();
    check("sync_search_en", 8'(sync_search_en), 8'h00);
    far.sample(8'h7F);
    settle();
    check("sync_search_en", 8'(sync_search_en), 8'h01);
    for (int m = 0; m < 4; m++)
      cca(m, 1'b1, 1'b0);
    far.level(1'b0, 1'b1);
    strobe(1'b0, 1'b1);
    far.level(1'b1, 1'b1);
    far.sample(8'h80);
    far.evt(6'h08);
    for (int m = 0; m < 4; m++)
      cca(m, 1'b0, 1'b1);
    far.evt(6'h02);
    #1;
    check("append_valid", 8'(append_out.valid), 8'h00);
    // an abort ends the packet but leaves the quality window running
    rc(4'h5, 8'h22);
    // frozen readout, quality over 64 symbols, appended status
    wr(4'h3, 8'h01);
    far.evt(6'h10);
    far.sample(8'hC4);
    rc(4'h6, 8'hC4);
    far.evt(6'h08);
    far.sample(8'hB0);
    rc(4'h6, 8'hC4);
    rc(4'h5, 8'h24);
    far.symbols(63, 0);
    rc(4'h5, 8'h24);
    far.symbols(1, 63);
    rc(4'h5, 8'h04);
    rc(4'h7, 8'h3C);
    far.symbols(4, 15);
    rc(4'h7, 8'h3C);
    far.evt(6'h04);
    #1;
    check("append_valid", 8'(append_out.valid), 8'h01);
    check("append_rssi", append_out.rssi_byte, 8'hC4);
    check("append_quality", append_out.quality_byte, 8'hBC);
    @(posedge mclk);
    #1;
    check("append_valid", 8'(append_out.valid), 8'h00);
    rc(4'h5, 8'h02);
    far.evt(6'h10);
    far.sample(8'hD0);
    rc(4'h6, 8'hD0);
    // pin 0 forced low, pin 1 receiving, pin 2 channel clear
    wr(4'h4, 8'h1B);
    settle();
    check("pins", 8'(general_output_pin), 8'h04);
    // bad checksum goes into the appended quality byte
    far.level(1'b1, 1'b0);
    far.evt(6'h08);
    settle();
    check("pins", 8'(general_output_pin), 8'h02);
    far.evt(6'h04);
    #1;
    check("append_valid", 8'(append_out.valid), 8'h01);
    check("append_rssi", append_out.rssi_byte, 8'hD0);
    check("append_quality", append_out.quality_byte, 8'h3C);
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
